// *** hw/sdo_cfg.svh ***
// Offsets, field positions and reset values of the slot output block.
// Included by the design modules; definitions only.
`ifndef SDO_CFG_SVH
`define SDO_CFG_SVH
`define SDO_IDX_SLOT_SEL      16'h217F
`define SDO_IDX_PORT_BASE     16'h2180
`define SDO_IDX_CYC_BASE      16'h7000
`define SDO_SUB_SLOT_SEL      8'h01
`define SDO_SUB_READBACK      8'h01
`define SDO_SUB_FAILSAFE      8'h02
`define SDO_SUB_CYC_FIRST     8'h01
`define SDO_SLOT_SEL_MAX      8'h07
`define SDO_SLOT_DIGIT_LSB    4
`define SDO_RST_OUT           8'h00
`define SDO_RST_FSV           8'h00
`define SDO_RST_SLOT          8'h00
`endif

// *** hw/sdo_pkg.sv ***
// Types of the slot digital output block.
// Assumes sdo_cfg.svh alongside.
package sdo_pkg;
    typedef enum logic [2:0] {
        SDO_ST_INIT   = 3'b001,
        SDO_ST_PREOP  = 3'b010,
        SDO_ST_OP     = 3'b100
    } sdo_state_t;
    typedef logic [7:0] sdo_byte_t;
endpackage

// *** hw/sdo_port_if.sv ***
// Interface between the object decoder and the port bank.
// Assumes a single clock domain.
interface sdo_port_if #(parameter int PORTS = 4);
    logic [PORTS-1:0]   out_we;
    logic [PORTS-1:0]   fsv_we;
    logic [7:0]         wdata;
    logic               trip;
    logic [8*PORTS-1:0] out_q;
    logic [8*PORTS-1:0] fsv_q;
    logic [8*PORTS-1:0] pin_q;
    modport ctl  (output out_we, fsv_we, wdata, trip, input out_q, fsv_q, pin_q);
    modport bank (input out_we, fsv_we, wdata, trip, output out_q, fsv_q, pin_q);
endinterface

// *** hw/sdo_port_bank.sv ***
// Output and fail-safe bytes for all ports, and the channel drive.
// Assumes write strobes are one-cycle pulses from the decoder.
`include "sdo_cfg.svh"
module sdo_port_bank #(
    parameter int PORTS = 4
) (
    input  wire logic clk,
    input  wire logic rst,
    sdo_port_if.bank  pif
);
    logic [8*PORTS-1:0] out_r, next_out;
    logic [8*PORTS-1:0] fsv_r, next_fsv;
    logic [8*PORTS-1:0] pin_r, next_pin;
    logic               held, next_held;

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    always_comb begin
        next_out  = out_r;
        next_fsv  = fsv_r;
        next_held = held;
        for (int p = 0; p < PORTS; p++) begin
            // Port p byte drives channels 8p+7..8p
            if (pif.out_we[p]) begin
                next_out[8*p +: 8] = pif.wdata;
            end
            if (pif.fsv_we[p]) begin
                next_fsv[8*p +: 8] = pif.wdata; // bit7 = local ch7
            end
        end
        if (pif.trip) begin
            next_held = 1'b1;
        end else if (|pif.out_we) begin
            next_held = 1'b0; // Fresh cyclic data releases the hold
        end
        // Trip forces ones, zero bits keep last level
        next_pin = next_held ? (next_out | next_fsv) : next_out; // 1 high, 0 low
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_r <= {PORTS{`SDO_RST_OUT}};
            fsv_r <= {PORTS{`SDO_RST_FSV}};
            pin_r <= '0;
            held  <= 1'b0;
        end else begin
            out_r <= next_out;
            fsv_r <= next_fsv;
            pin_r <= next_pin;
            held  <= next_held;
        end
    end

    assign pif.out_q = out_r;
    assign pif.fsv_q = fsv_r;
    assign pif.pin_q = pin_r;
endmodule

// *** hw/sdo_slot_output.sv ***
// Top of the slot digital output block: object dictionary access and channel outputs.
// Assumes the fieldbus core presents decoded object accesses synchronous to clk.
//
// Behaviour
// - Thirty-two channels organised as four ports of eight channels each.
// - Cyclic output bytes at sub-indices 01h-04h, write only, only when operational.
// - First port byte: bit 7 drives channel 7, bit 0 channel 0.
// - Last port byte: bit 7 drives channel 31, bit 0 channel 24.
// - Bit one drives channel high, bit zero drives it low.
// - Slots numbered 00h leftmost to 07h rightmost.
// - Slot select at 217Fh:01h, read-write, 0-7, pre-operational or operational.
// - Port output readback at 2180h+port sub-index 01h, read only.
// - Fail-safe byte at sub-index 02h; enabled watchdog trip applies fail-safe levels.
// - Fail-safe bit one forces channel high; zero disables forcing.
// - Fail-safe byte bit 7 is local channel 7, bit 0 channel 0.
`include "sdo_cfg.svh"
module sdo_slot_output #(
    parameter int        PORTS   = 4,
    parameter logic [7:0] MY_SLOT = 8'h00
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          state_preop,
    input  wire logic          state_op,
    input  wire logic          cyc_wr,
    input  wire logic [15:0]   cyc_index,
    input  wire logic [7:0]    cyc_sub,
    input  wire logic [7:0]    cyc_data,
    input  wire logic          acy_req,
    input  wire logic          acy_we,
    input  wire logic [15:0]   acy_index,
    input  wire logic [7:0]    acy_sub,
    input  wire logic [7:0]    acy_wdata,
    input  wire logic          wdog_enable,
    input  wire logic          wdog_expired,
    output logic               acy_ack,
    output logic               acy_err,
    output logic [7:0]         acy_rdata,
    output logic [7:0]         slot_select,
    output logic               fail_safe_active,
    output logic [8*PORTS-1:0] chan_out
);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (PORTS < 1 || PORTS > 8) begin : g_bad_ports
        $error("PORTS must be 1 to 8");
    end
    if (MY_SLOT > `SDO_SLOT_SEL_MAX) begin : g_bad_slot
        $error("MY_SLOT must be 0 to 7");
    end

    // ----------------------------------------
    // Port bank
    // ----------------------------------------
    sdo_port_if #(.PORTS(PORTS)) pif ();

    sdo_port_bank #(.PORTS(PORTS)) u_bank (
        .clk (clk),
        .rst (rst),
        .pif (pif)
    );

    // ----------------------------------------
    // Operating state
    // ----------------------------------------
    sdo_pkg::sdo_state_t cur_state;
    logic [7:0]          next_slot;
    logic                next_ack, next_err;
    logic [7:0]          next_rdata;
    logic                next_fs;
    logic [PORTS-1:0]    out_we, fsv_we;
    logic                wr_any;
    logic [7:0]          wdata;
    logic                cyc_open, acy_open;

    always_comb begin
        if (state_op) begin
            cur_state = sdo_pkg::SDO_ST_OP;
        end else if (state_preop) begin
            cur_state = sdo_pkg::SDO_ST_PREOP;
        end else begin
            cur_state = sdo_pkg::SDO_ST_INIT;
        end
    end

    // Which kinds of access each state admits
    always_comb begin
        cyc_open = 1'b0;
        acy_open = 1'b0;
        unique case (cur_state)
            sdo_pkg::SDO_ST_OP: begin
                cyc_open = 1'b1;
                acy_open = 1'b1;
            end
            sdo_pkg::SDO_ST_PREOP: begin
                acy_open = 1'b1;
            end
            sdo_pkg::SDO_ST_INIT: begin
                acy_open = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Object helpers
    // ----------------------------------------
    // Port number of a 2180h-based index, or PORTS when not a port object
    function automatic int port_of(input logic [15:0] idx);
        int r;
        r = PORTS;
        for (int p = 0; p < PORTS; p++) begin
            if (idx == `SDO_IDX_PORT_BASE + 16'(p)) begin
                r = p;
            end
        end
        return r;
    endfunction

    // Port number of a cyclic sub-index, or PORTS when out of range
    function automatic int cyc_port_of(input logic [7:0] sub);
        int r;
        r = PORTS;
        for (int p = 0; p < PORTS; p++) begin
            if (sub == `SDO_SUB_CYC_FIRST + 8'(p)) begin
                r = p;
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // Cyclic and acyclic decode
    // ----------------------------------------
    always_comb begin
        int pa;
        int pc;
        logic [15:0] my_cyc;
        pa         = port_of(acy_index);
        pc         = cyc_port_of(cyc_sub);
        // Own cyclic object index: slot in the x digit
        my_cyc     = `SDO_IDX_CYC_BASE | (16'(MY_SLOT[3:0]) << `SDO_SLOT_DIGIT_LSB);
        out_we     = '0;
        fsv_we     = '0;
        wdata      = acy_wdata;
        next_slot  = slot_select;
        next_ack   = 1'b0;
        next_err   = 1'b0;
        next_rdata = 8'h00;
        // Cyclic bytes accepted only when operational
        if (cyc_wr && cyc_open && cyc_index == my_cyc && pc < PORTS) begin
            out_we[pc] = 1'b1;
            wdata      = cyc_data;
        end else if (acy_req) begin
            next_ack = 1'b1;
            if (!acy_open) begin
                next_err = 1'b1;
            end else if (acy_index == `SDO_IDX_SLOT_SEL && acy_sub == `SDO_SUB_SLOT_SEL) begin
                // Slot select, range 0-7
                if (!acy_we) begin
                    next_rdata = slot_select;
                end else if (acy_wdata <= `SDO_SLOT_SEL_MAX) begin
                    next_slot = acy_wdata;
                end else begin
                    next_err = 1'b1;
                end
            end else if (pa < PORTS && slot_select == MY_SLOT) begin
                if (acy_sub == `SDO_SUB_READBACK) begin
                    // Readback is read only
                    next_err   = acy_we;
                    next_rdata = acy_we ? 8'h00 : pif.out_q[8*pa +: 8];
                end else if (acy_sub == `SDO_SUB_FAILSAFE) begin
                    // Fail-safe byte per port
                    if (acy_we) begin
                        fsv_we[pa] = 1'b1;
                    end else begin
                        next_rdata = pif.fsv_q[8*pa +: 8];
                    end
                end else begin
                    next_err = 1'b1;
                end
            end else begin
                next_err = 1'b1;
            end
        end
        wr_any  = |out_we;
        // Trip only when the watchdog is enabled
        next_fs = (wdog_enable && wdog_expired) ? 1'b1 : (wr_any ? 1'b0 : fail_safe_active);
    end

    // ----------------------------------------
    // Bank strobes
    // ----------------------------------------
    assign pif.out_we = out_we;
    assign pif.fsv_we = fsv_we;
    assign pif.wdata  = wdata;
    assign pif.trip   = wdog_enable && wdog_expired;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_select      <= `SDO_RST_SLOT;
            acy_ack          <= 1'b0;
            acy_err          <= 1'b0;
            acy_rdata        <= 8'h00;
            fail_safe_active <= 1'b0;
        end else begin
            slot_select      <= next_slot;
            acy_ack          <= next_ack;
            acy_err          <= next_err;
            acy_rdata        <= next_rdata;
            fail_safe_active <= next_fs;
        end
    end

    // ----------------------------------------
    // Channel outputs
    // ----------------------------------------
    // Channel levels, 1 high and 0 low
    assign chan_out = pif.pin_q;
endmodule

// *** verification/sdo_master_model.sv ***
// Fieldbus master model: cyclic and acyclic object accesses.
// Assumes the block samples each request at one rising edge of clk.
module sdo_master_model (
    input  wire logic   clk,
    output logic        cyc_wr,
    output logic [15:0] cyc_index,
    output logic [7:0]  cyc_sub,
    output logic [7:0]  cyc_data,
    output logic        acy_req,
    output logic        acy_we,
    output logic [15:0] acy_index,
    output logic [7:0]  acy_sub,
    output logic [7:0]  acy_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Requests; released lines show inverse
    // ----------------------------------------
    initial begin
        {cyc_wr, cyc_index, cyc_sub, cyc_data} = '0;
        {acy_req, acy_we, acy_index, acy_sub, acy_wdata} = '0;
    end
    task automatic cyc(input logic [7:0] slot, input logic [7:0] sub, input logic [7:0] d);
        @(posedge clk);
        {cyc_wr, cyc_index, cyc_sub, cyc_data} <= {1'b1, 8'h70, slot[3:0], 4'h0, sub, d};
        @(posedge clk);
        {cyc_wr, cyc_index, cyc_sub, cyc_data} <= {1'b0, ~cyc_index, ~sub, ~d};
    endtask
    task automatic acy(input logic we, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [7:0] wd);
        @(posedge clk);
        {acy_req, acy_we, acy_index, acy_sub, acy_wdata} <= {1'b1, we, idx, sub, wd};
        @(posedge clk);
        {acy_req, acy_we, acy_index, acy_sub, acy_wdata} <= {1'b0, ~we, ~idx, ~sub, ~wd};
    endtask
endmodule

// *** verification/sdo_slot_output_sva.sv ***
// Checker of the slot output block, bound to its top module.
// Assumes one clock domain with asynchronous active-high reset.
module sdo_slot_output_sva #(
    parameter int         PORTS   = 4,
    parameter logic [7:0] MY_SLOT = 8'h00
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               state_preop,
    input wire logic               state_op,
    input wire logic               cyc_wr,
    input wire logic [15:0]        cyc_index,
    input wire logic [7:0]         cyc_sub,
    input wire logic [7:0]         cyc_data,
    input wire logic               acy_req,
    input wire logic               acy_we,
    input wire logic [15:0]        acy_index,
    input wire logic [7:0]         acy_sub,
    input wire logic [7:0]         acy_wdata,
    input wire logic               wdog_enable,
    input wire logic               wdog_expired,
    input wire logic               acy_ack,
    input wire logic               acy_err,
    input wire logic [7:0]         slot_select,
    input wire logic               fail_safe_active,
    input wire logic [8*PORTS-1:0] chan_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    localparam logic [15:0] CYC = {8'h70, MY_SLOT[3:0], 4'h0};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take; acy_req && !cyc_wr; endsequence
    sequence s_trip; wdog_enable && wdog_expired; endsequence
    wire trip = wdog_enable && wdog_expired;
    wire cyc_ok = cyc_wr && state_op && cyc_index == CYC && !trip;
    AST_ACK_LAT: assert property (s_take |=> acy_ack) else $error("no ack");
    AST_ACK_CAUSE: assert property (acy_ack |-> $past(acy_req)) else $error("stray ack");
    AST_INIT_ERR: assert property (s_take ##0 !(state_preop || state_op) |=> acy_err)
        else $error("init access accepted");
    AST_SLOT_MAX: assert property (s_take ##0 (acy_we && acy_index == 16'h217F
        && acy_wdata > 8'h07) |=> acy_err && $stable(slot_select)) else $error("slot range");
    AST_RB_RO: assert property (s_take ##0 (acy_we && acy_sub == 8'h01
        && acy_index inside {[16'h2180:16'h2183]}) |=> acy_err) else $error("readback written");
    AST_OP_ONLY: assert property (!state_op && !trip && !fail_safe_active |=> $stable(chan_out))
        else $error("output moved outside op");
    AST_LOW_BYTE: assert property (cyc_ok && cyc_sub == 8'h01
        |=> chan_out[7:0] == $past(cyc_data) && !fail_safe_active) else $error("low byte");
    AST_TOP_BYTE: assert property (cyc_ok && cyc_sub == 8'(PORTS)
        |=> chan_out[8*PORTS-1 -: 8] == $past(cyc_data)) else $error("top byte");
    AST_TRIP: assert property (s_trip |=> fail_safe_active) else $error("trip missed");
    AST_TRIP_CAUSE: assert property ($rose(fail_safe_active) |-> $past(trip))
        else $error("fail-safe without trip");
    AST_FS_HOLD: assert property (fail_safe_active && !cyc_wr |=> fail_safe_active)
        else $error("fail-safe dropped");
    AST_FORCE_UP: assert property (s_trip ##0 !fail_safe_active ##0 !cyc_wr
        |=> (chan_out & $past(chan_out)) == $past(chan_out)) else $error("forcing lowered");
endmodule
bind sdo_slot_output sdo_slot_output_sva #(.PORTS(PORTS), .MY_SLOT(MY_SLOT)) i_sva (.*);

// *** verification/testbench.sv ***
// Self-checking bench of the slot output block, block placed in slot 01h.
// Assumes the master model makes every object access.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus and scoreboard
    // ----------------------------------------
    localparam logic [7:0] SLOT = 8'h01;
    logic        clk = 1'b0, rst = 1'b1, state_preop = 1'b0, state_op = 1'b0;
    logic        wdog_enable = 1'b0, wdog_expired = 1'b0;
    logic        cyc_wr, acy_req, acy_we, acy_ack, acy_err, fail_safe_active;
    logic [15:0] cyc_index, acy_index;
    logic [7:0]  cyc_sub, cyc_data, acy_sub, acy_wdata, acy_rdata, slot_select;
    logic [31:0] chan_out;
    logic [3:0][7:0] d, f;
    logic [8:0]  exp_q[$];
    int          err_count = 0, num_checks = 0, tick = 0;
    sdo_master_model i_sdo_master_model (.*);
    sdo_slot_output #(.PORTS(4), .MY_SLOT(SLOT)) i_sdo_slot_output (.*);
    initial forever #12.5 clk = ~clk;
    task automatic test_done;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic report(input logic [32:0] e, input logic [32:0] a);
        num_checks++;
        if (a !== e) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic chk_ack(input logic [8:0] e, input logic [8:0] a);
        report({24'h0, e}, {24'h0, a});
    endtask
    task automatic chk_out(input logic [32:0] e);
        @(negedge clk);
        report(e, {fail_safe_active, chan_out});
    endtask
    task automatic chk_slot(input logic [7:0] e);
        @(negedge clk);
        report({25'h0, e}, {25'h0, slot_select});
    endtask
    task automatic acy(input logic we, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [7:0] wd, input logic [8:0] e);
        exp_q.push_back(e);
        i_sdo_master_model.acy(we, idx, sub, wd);
    endtask
    always @(negedge clk) begin
        if (acy_ack === 1'b1)
            chk_ack(exp_q.size() ? exp_q.pop_front() : 9'h1FF, {acy_err, acy_rdata});
    end
    always @(posedge clk) begin
        tick <= tick + 1;
        if (tick == 3000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        void'($urandom(57));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        acy(1'b0, 16'h217F, 8'h01, 8'h00, 9'h100);
        @(posedge clk) state_preop <= 1'b1;
        acy(1'b1, 16'h217F, 8'h01, 8'h08, 9'h100);
        acy(1'b0, 16'h2180, 8'h01, 8'h00, 9'h100);
        acy(1'b1, 16'h217F, 8'h01, SLOT, 9'h000);
        acy(1'b0, 16'h217F, 8'h01, 8'h00, {1'b0, SLOT});
        chk_slot(SLOT);
        i_sdo_master_model.cyc(SLOT, 8'h01, 8'hFF);
        chk_out(33'h0);
        @(posedge clk) state_op <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            d[p] = 8'($urandom);
            f[p] = 8'($urandom);
            i_sdo_master_model.cyc(SLOT, 8'(p + 1), d[p]);
            acy(1'b1, 16'h2180 + 16'(p), 8'h02, f[p], 9'h000);
        end
        i_sdo_master_model.cyc(8'h00, 8'h01, ~d[0]);
        chk_out({1'b0, d});
        for (int p = 0; p < 4; p++) begin
            acy(1'b0, 16'h2180 + 16'(p), 8'h01, 8'h00, {1'b0, d[p]});
            acy(1'b0, 16'h2180 + 16'(p), 8'h02, 8'h00, {1'b0, f[p]});
        end
        acy(1'b1, 16'h2181, 8'h01, 8'h00, 9'h100);
        acy(1'b0, 16'h2184, 8'h01, 8'h00, 9'h100);
        @(posedge clk) wdog_expired <= 1'b1;
        @(posedge clk) wdog_expired <= 1'b0;
        chk_out({1'b0, d});
        @(posedge clk) {wdog_enable, wdog_expired} <= 2'b11;
        @(posedge clk) wdog_expired <= 1'b0;
        chk_out({1'b1, d | f});
        d[0] = 8'h5A;
        i_sdo_master_model.cyc(SLOT, 8'h01, d[0]);
        chk_out({1'b0, d});
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        chk_out(33'h0);
        chk_slot(8'h00);
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0)
            err_count++;
        test_done();
    end
endmodule
